// ==== inc/tcc_pkg.sv ====
// constants shared by the timer block and its channel module
package tcc_pkg;
  localparam int ADDR_W = 8;
  localparam int VAL_W = 16;
  localparam int PRE_W = 7;
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_TSC = 6'h20;
  localparam logic [5:0] IDX_CNT_HI = 6'h22;
  localparam logic [5:0] IDX_CNT_LO = 6'h23;
  localparam logic [5:0] IDX_MOD_HI = 6'h24;
  localparam logic [5:0] IDX_MOD_LO = 6'h25;
  localparam logic [5:0] IDX_SC0 = 6'h26;
  localparam logic [5:0] IDX_CH0_HI = 6'h27;
  localparam logic [5:0] IDX_CH0_LO = 6'h28;
  localparam logic [5:0] IDX_SC1 = 6'h29;
  localparam logic [5:0] IDX_CH1_HI = 6'h2A;
  localparam logic [5:0] IDX_CH1_LO = 6'h2B;
  // timer status/control fields
  localparam int TSC_OVF_BIT = 7;
  localparam int TSC_HALT_BIT = 5;
  localparam int TSC_CLR_BIT = 4;
  localparam int TSC_PS_LSB = 0;
  localparam logic [2:0] PS_EXT = 3'h7;
  // channel status/control fields
  localparam int SC_FLAG_BIT = 7;
  localparam int SC_IE_BIT = 6;
  localparam int SC_BUF_BIT = 5;
  localparam int SC_MSA_BIT = 4;
  localparam int SC_ELS_LSB = 2;
  localparam int SC_TOV_BIT = 1;
  localparam int SC_MAX_BIT = 0;
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  // reset values
  localparam logic HALT_RST = 1'h1;
  localparam logic [2:0] PS_RST = 3'h0;
  localparam logic [15:0] MOD_RST = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic LEVEL_RST = 1'h1;
  localparam logic [7:0] BYTE_RST = 8'h00;
endpackage

// ==== hdl/tcc_chan.sv ====
// one capture/compare/pwm channel with its status/control and value registers
`timescale 1ns/10ps
module tcc_chan #(
  parameter bit HAS_BUF = 1'b0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [tcc_pkg::VAL_W-1:0] cnt,
  input wire logic cnt_new,
  input wire logic ovf,
  input wire logic sc_off,
  input wire logic sc_wr,
  input wire logic sc_rd,
  input wire logic hi_wr,
  input wire logic lo_wr,
  input wire logic hi_rd,
  input wire logic lo_rd,
  input wire logic [7:0] wdata,
  input wire logic pin_in,
  output logic [7:0] sc_val,
  output logic [tcc_pkg::VAL_W-1:0] value,
  output logic buf_mode,
  output logic pin_out,
  output logic pin_oe_n,
  output logic irq
);
  import tcc_pkg::*;

  typedef struct packed {
    logic flag;
    logic ie;
    logic bufm;
    logic msa;
    logic [1:0] els;
    logic tov;
    logic maxc;
    logic max_eff;
    logic armed;
    logic cap_lock;
    logic cmp_lock;
    logic [15:0] val;
    logic [15:0] act;
    logic pin_prev;
    logic level;
    logic oe_n;
    logic irq;
  } tcc_chan_st_t;

  tcc_chan_st_t s;
  tcc_chan_st_t n;
  logic cap_m;
  logic cmp_m;
  logic cap_ev;
  logic match;
  logic ev;

  // next state of the channel
  always_comb begin
    n = s;
    cap_m = (s.els != ELS_OFF) && !s.bufm && !s.msa && !sc_off;
    cmp_m = (s.els != ELS_OFF) && (s.bufm || s.msa) && !sc_off;
    cap_ev = cap_m && !s.cap_lock &&
      ((s.els[0] && pin_in && !s.pin_prev) || (s.els[1] && !pin_in && s.pin_prev));
    match = cmp_m && cnt_new && !s.cmp_lock && (cnt == (s.bufm ? s.act : s.val));
    ev = cap_ev || match;
    n.pin_prev = pin_in;
    if (cap_ev) begin
      n.val = cnt;
    end
    // control fields; a disabled register ignores writes
    if (sc_wr && !sc_off) begin
      n.ie = wdata[SC_IE_BIT];
      n.bufm = HAS_BUF ? wdata[SC_BUF_BIT] : 1'b0;
      n.msa = wdata[SC_MSA_BIT];
      n.els = wdata[SC_ELS_LSB +: 2];
      n.tov = wdata[SC_TOV_BIT];
      n.maxc = wdata[SC_MAX_BIT];
      if (!wdata[SC_FLAG_BIT] && s.armed && !ev) begin
        n.flag = 1'b0;
      end
      n.armed = 1'b0;
    end
    if (sc_rd && s.flag && !sc_off) begin
      n.armed = 1'b1;
    end
    // byte interlocks on the value register
    if (hi_rd && !s.bufm && !s.msa) begin
      n.cap_lock = 1'b1;
    end
    if (lo_rd) begin
      n.cap_lock = 1'b0;
    end
    if (hi_wr) begin
      n.val[15:8] = wdata;
      n.cmp_lock = s.bufm || s.msa;
    end
    if (lo_wr) begin
      n.val[7:0] = wdata;
      n.cmp_lock = 1'b0;
    end
    // buffered compare takes the new value only at a period boundary
    if (!s.bufm) begin
      n.act = s.val;
    end else if (ovf) begin
      n.act = s.val;
    end
    if (ovf) begin
      n.max_eff = s.maxc;
    end
    // pin level
    if (cmp_m) begin
      if (s.tov && ovf) begin
        n.level = !s.level;
      end else if (match) begin
        unique case (s.els)
          ELS_TOGGLE: n.level = !s.level;
          ELS_CLEAR: n.level = 1'b0;
          ELS_SET: n.level = 1'b1;
          ELS_OFF: n.level = s.level;
        endcase
      end
      if (s.max_eff && !s.tov) begin
        n.level = 1'b1;
      end
    end else if (s.els == ELS_OFF) begin
      n.level = !s.msa;
    end
    n.oe_n = !cmp_m;
    // a new event beats a clear in the same cycle
    if (ev) begin
      n.flag = 1'b1;
      n.armed = 1'b0;
    end
    n.irq = n.flag && n.ie;
  end

  // all channel state; reset clears every control bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '{flag: 1'b0, ie: 1'b0, bufm: 1'b0, msa: 1'b0, els: ELS_OFF, tov: 1'b0,
             maxc: 1'b0, max_eff: 1'b0, armed: 1'b0, cap_lock: 1'b0, cmp_lock: 1'b0,
             val: VAL_RST, act: VAL_RST, pin_prev: 1'b0, level: LEVEL_RST, oe_n: 1'b1, irq: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign sc_val = sc_off ? BYTE_RST : {s.flag, s.ie, s.bufm, s.msa, s.els, s.tov, s.maxc};
  assign value = s.val;
  assign buf_mode = s.bufm;
  assign pin_out = s.level;
  assign pin_oe_n = s.oe_n;
  assign irq = s.irq;
endmodule

// ==== hdl/tcc_timer.sv ====
// two-channel capture/compare timer with its counter, behind an apb slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module tcc_timer (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] ch_pin_in,
  input wire logic counter_ext_clk,
  output logic [1:0] ch_pin_out,
  output logic [1:0] ch_pin_oe_n,
  output logic [1:0] chan_irq_req
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [7:0] rdata;
    logic ready;
    logic err;
    logic halt;
    logic [2:0] ps;
    logic [6:0] pre;
    logic ext_q;
    logic [15:0] cnt;
    logic [15:0] modv;
    logic mod_lock;
    logic cnt_new;
    logic ovf;
    logic ovf_flag;
    logic ovf_armed;
    logic [7:0] lo_latch;
    logic latched;
  } tcc_top_st_t;

  tcc_top_st_t s;
  tcc_top_st_t n;

  logic [5:0] idx;
  logic aligned;
  logic acc;
  logic done;
  logic wr;
  logic rd;
  logic [7:0] wb;
  logic [7:0] sc0_val;
  logic [7:0] sc1_val;
  logic [15:0] val0;
  logic [15:0] val1;
  logic buf0;
  logic buf1_unused;

  // apb phases: the access phase is answered one cycle later
  assign idx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign acc = psel && penable && !s.ready;
  assign done = psel && penable && s.ready;
  assign wr = done && pwrite && aligned;
  assign rd = done && !pwrite && aligned;
  assign wb = pwdata[7:0];

  logic map_ok;
  logic [7:0] rmux;
  logic [6:0] mask;
  logic tick;
  logic tsc_wr;
  logic clr;

  // read decode; unmapped indices answer with an error and zero data
  always_comb begin
    map_ok = 1'b1;
    rmux = BYTE_RST;
    unique case (idx)
      IDX_TSC: begin
        rmux[TSC_OVF_BIT] = s.ovf_flag;
        rmux[TSC_HALT_BIT] = s.halt;
        rmux[TSC_PS_LSB +: 3] = s.ps;
      end
      IDX_CNT_HI: begin
        rmux = s.cnt[15:8];
      end
      IDX_CNT_LO: begin
        rmux = s.latched ? s.lo_latch : s.cnt[7:0];
      end
      IDX_MOD_HI: begin
        rmux = s.modv[15:8];
      end
      IDX_MOD_LO: begin
        rmux = s.modv[7:0];
      end
      IDX_SC0: begin
        rmux = sc0_val;
      end
      IDX_CH0_HI: begin
        rmux = val0[15:8];
      end
      IDX_CH0_LO: begin
        rmux = val0[7:0];
      end
      IDX_SC1: begin
        rmux = sc1_val;
      end
      IDX_CH1_HI: begin
        rmux = val1[15:8];
      end
      IDX_CH1_LO: begin
        rmux = val1[7:0];
      end
      default: begin
        map_ok = 1'b0;
      end
    endcase
    if (!aligned) begin
      map_ok = 1'b0;
      rmux = BYTE_RST;
    end
  end

  // next state of bus answer and counter
  always_comb begin
    n = s;
    n.cnt_new = 1'b0;
    n.ovf = 1'b0;
    n.ext_q = counter_ext_clk;
    tsc_wr = wr && (idx == IDX_TSC);
    clr = tsc_wr && wb[TSC_CLR_BIT];
    // prescaler tap: divide by two to the power of the select field; select 7 takes external clock edges
    mask = 7'((8'h01 << s.ps) - 8'h01);
    if (s.ps == PS_EXT) begin
      tick = counter_ext_clk && !s.ext_q;
    end else begin
      tick = ((s.pre & mask) == mask);
    end
    // bus answer stands for exactly one cycle
    n.ready = acc;
    n.err = acc && !map_ok;
    if (acc) begin
      n.rdata = pwrite ? BYTE_RST : rmux;
    end
    // status/control writes
    if (tsc_wr) begin
      n.halt = wb[TSC_HALT_BIT];
      n.ps = wb[TSC_PS_LSB +: 3];
      if (!wb[TSC_OVF_BIT] && s.ovf_armed) begin
        n.ovf_flag = 1'b0;
      end
      n.ovf_armed = 1'b0;
    end
    if (rd && (idx == IDX_TSC) && s.ovf_flag) begin
      n.ovf_armed = 1'b1;
    end
    // modulo writes; the high byte holds off the overflow flag
    if (wr && (idx == IDX_MOD_HI)) begin
      n.modv[15:8] = wb;
      n.mod_lock = 1'b1;
    end
    if (wr && (idx == IDX_MOD_LO)) begin
      n.modv[7:0] = wb;
      n.mod_lock = 1'b0;
    end
    // reading the counter high byte freezes the low byte for software
    if (rd && (idx == IDX_CNT_HI) && !s.latched) begin
      n.lo_latch = s.cnt[7:0];
      n.latched = 1'b1;
    end
    if (rd && (idx == IDX_CNT_LO)) begin
      n.latched = 1'b0;
    end
    // counter; clear wins over counting and leaves other registers alone
    if (clr) begin
      n.cnt = CNT_RST;
      n.pre = 7'h00;
      n.latched = 1'b0;
    end else if (!s.halt) begin
      n.pre = s.pre + 7'h01;
      if (tick) begin
        n.cnt_new = 1'b1;
        if (s.cnt == s.modv) begin
          n.cnt = CNT_RST;
          n.ovf = 1'b1;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
    end
    // an overflow in the cycle of a flag clear write beats the clear
    if (n.ovf && !s.mod_lock) begin
      n.ovf_flag = 1'b1;
      n.ovf_armed = 1'b0;
    end
  end

  // all top-level state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '{rdata: BYTE_RST, ready: 1'b0, err: 1'b0, halt: HALT_RST, ps: PS_RST,
             pre: 7'h00, ext_q: 1'b0, cnt: CNT_RST, modv: MOD_RST, mod_lock: 1'b0,
             cnt_new: 1'b0, ovf: 1'b0, ovf_flag: 1'b0, ovf_armed: 1'b0,
             lo_latch: BYTE_RST, latched: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign prdata = {24'h000000, s.rdata};
  assign pready = s.ready;
  assign pslverr = s.err;

  // channel 0 owns the buffered select; it also shuts channel 1 off
  tcc_chan #(
    .HAS_BUF(1'b1)
  ) u_chan0 (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cnt(s.cnt),
    .cnt_new(s.cnt_new),
    .ovf(s.ovf),
    .sc_off(1'b0),
    .sc_wr(wr && (idx == IDX_SC0)),
    .sc_rd(rd && (idx == IDX_SC0)),
    .hi_wr(wr && (idx == IDX_CH0_HI)),
    .lo_wr(wr && (idx == IDX_CH0_LO)),
    .hi_rd(rd && (idx == IDX_CH0_HI)),
    .lo_rd(rd && (idx == IDX_CH0_LO)),
    .wdata(wb),
    .pin_in(ch_pin_in[0]),
    .sc_val(sc0_val),
    .value(val0),
    .buf_mode(buf0),
    .pin_out(ch_pin_out[0]),
    .pin_oe_n(ch_pin_oe_n[0]),
    .irq(chan_irq_req[0])
  );

  // channel 1 has no buffered select of its own
  tcc_chan #(
    .HAS_BUF(1'b0)
  ) u_chan1 (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cnt(s.cnt),
    .cnt_new(s.cnt_new),
    .ovf(s.ovf),
    .sc_off(buf0),
    .sc_wr(wr && (idx == IDX_SC1)),
    .sc_rd(rd && (idx == IDX_SC1)),
    .hi_wr(wr && (idx == IDX_CH1_HI)),
    .lo_wr(wr && (idx == IDX_CH1_LO)),
    .hi_rd(rd && (idx == IDX_CH1_HI)),
    .lo_rd(rd && (idx == IDX_CH1_LO)),
    .wdata(wb),
    .pin_in(ch_pin_in[1]),
    .sc_val(sc1_val),
    .value(val1),
    .buf_mode(buf1_unused),
    .pin_out(ch_pin_out[1]),
    .pin_oe_n(ch_pin_oe_n[1]),
    .irq(chan_irq_req[1])
  );
endmodule

// ==== tb/tcc_timer_sva.sv ====
// port-level checker for the two-channel timer
`timescale 1ns/10ps
module tcc_timer_sva
  import tcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] ch_pin_in,
  input wire logic counter_ext_clk,
  input wire logic [1:0] ch_pin_out,
  input wire logic [1:0] ch_pin_oe_n,
  input wire logic [1:0] chan_irq_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // completed write to channel 0 control and its data byte
  logic wr0;
  logic [7:0] d;
  assign wr0 = psel && penable && pready && pwrite && paddr == {IDX_SC0, 2'h0};
  assign d = pwdata[7:0];
  AST_RDY_ONE: assert property (psel && penable && !pready |=> pready) else $error("ready late");
  AST_UNALIGNED: assert property (psel && penable && !pready && paddr[1:0] != 2'h0 |=> pready && pslverr)
    else $error("unaligned access accepted");
  AST_ERR_DATA: assert property (pready && pslverr |-> prdata == 32'h0) else $error("error read not zero");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_RST_OUT: assert property ($rose(resetn) |-> ch_pin_oe_n == 2'h3 && chan_irq_req == 2'h0)
    else $error("outputs wrong after reset");
  AST_IE_OFF: assert property (wr0 && !d[SC_IE_BIT] |-> ##2 !chan_irq_req[0])
    else $error("request kept with enable off");
  AST_PRESET: assert property (wr0 && d[3:2] == ELS_OFF |-> ##3 ch_pin_oe_n[0] && ch_pin_out[0] == !$past(d[4], 3))
    else $error("preset level or release wrong");
  AST_CMP_DRIVE: assert property (wr0 && d[3:2] != ELS_OFF && d[5:4] != 2'h0 |-> ##3 !ch_pin_oe_n[0])
    else $error("compare mode does not drive pin");
  AST_CAP_FREE: assert property (wr0 && d[3:2] != ELS_OFF && d[5:4] == 2'h0 |-> ##3 ch_pin_oe_n[0])
    else $error("capture mode drives pin");
  // main scenarios reached
  cover property (chan_irq_req[0]);
  cover property (chan_irq_req[1]);
  cover property (pready && pslverr);
endmodule
bind tcc_timer tcc_timer_sva SVA (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .ch_pin_in, .counter_ext_clk, .ch_pin_out, .ch_pin_oe_n, .chan_irq_req);

// ==== tb/tcc_pin_model.sv ====
// external circuit on the two channel pins
`timescale 1ns/10ps
module tcc_pin_model (
  input wire logic [1:0] drv,
  input wire logic [1:0] ch_pin_out,
  input wire logic [1:0] ch_pin_oe_n,
  output logic [1:0] ch_pin_in
);
  // wire level: the block wins while it drives, else the outside source; no contention modelled
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ch_pin_in[i] = ch_pin_oe_n[i] ? drv[i] : ch_pin_out[i];
    end
  end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the two-channel timer
`timescale 1ns/10ps
module tb;
  import tcc_pkg::*;
  typedef struct packed {logic [5:0] idx; logic [7:0] d; logic [7:0] exp; logic err;} tcc_row_t;
  logic clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, counter_ext_clk = 1'b0;
  logic [7:0] paddr = 8'h00, q, m;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, e, pv;
  logic [1:0] ch_pin_in, ch_pin_out, ch_pin_oe_n, irq, drv = 2'h0;
  int mismatches = 0, checks = 0, tg = 0;
  // write then read back; clear bit reads 0, counter ignores writes, channel 1 locked out while buffered
  tcc_row_t rows [9] = '{'{IDX_TSC, 8'h30, 8'h20, 1'b0}, '{IDX_CNT_HI, 8'hFF, 8'h00, 1'b0},
    '{IDX_SC0, 8'hFF, 8'h7F, 1'b0}, '{IDX_SC1, 8'h5C, 8'h00, 1'b0}, '{IDX_SC0, 8'h00, 8'h00, 1'b0},
    '{IDX_SC1, 8'hFF, 8'h5F, 1'b0}, '{IDX_SC1, 8'h00, 8'h00, 1'b0}, '{6'h21, 8'h55, 8'h00, 1'b1},
    '{IDX_TSC, 8'h27, 8'h27, 1'b0}};
  // clocks: external counter clock runs at a quarter of the bus clock rate, in step with it
  always #50 clk_sys = ~clk_sys;
  // edges fall on bus clock low phases so the input never changes at a sampling edge
  always #200 counter_ext_clk = ~counter_ext_clk;
  tcc_timer DUT (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ch_pin_in, .counter_ext_clk, .ch_pin_out, .ch_pin_oe_n, .chan_irq_req(irq));
  tcc_pin_model PIN (.drv, .ch_pin_out, .ch_pin_oe_n, .ch_pin_in);
  task final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // apb cycle: setup, access, hold until ready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] dt);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, dt};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      final_report();
    end
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [5:0] idx, input logic [7:0] dt);
    xfer(1'b1, {idx, 2'h0}, dt);
  endtask
  task rd(input string n, input logic [5:0] idx, input logic [7:0] exp);
    xfer(1'b0, {idx, 2'h0}, 8'h00);
    chk(n, q, exp);
  endtask
  // flag clear needs a read first, so do both
  task clr(input logic [5:0] idx, input logic [7:0] sc);
    xfer(1'b0, {idx, 2'h0}, 8'h00);
    wr(idx, sc);
  endtask
  task wait_irq(input int i);
    int n;
    n = 0;
    while (irq[i] !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 300) begin
      mismatches++;
      final_report();
    end
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].d);
      rd("row", rows[i].idx, rows[i].exp);
      chk("err", 8'(e), 8'(rows[i].err));
    end
    xfer(1'b0, 8'h99, 8'h00);
    chk("unaligned", 8'(e), 8'h01);
    wr(IDX_CH0_HI, 8'h00);
    wr(IDX_CH0_LO, 8'h40);
    // compare actions toggle, clear, set from a preset level
    for (int s = 1; s < 4; s++) begin
      m = 8'(s << 2);
      wr(IDX_TSC, 8'h30);
      wr(IDX_SC0, (s == 2) ? 8'h40 : 8'h50);
      repeat (3) @(posedge clk_sys);
      chk("preset", 8'(ch_pin_out[0]), 8'(s == 2));
      wr(IDX_SC0, 8'h50 | m);
      wr(IDX_TSC, 8'h00);
      wait_irq(0);
      repeat (2) @(posedge clk_sys);
      chk("action", 8'(ch_pin_out[0]), 8'(s != 2));
      wr(IDX_TSC, 8'h30);
      rd("flag", IDX_SC0, 8'hD0 | m);
      wr(IDX_SC0, 8'h90 | m);
      rd("flag kept", IDX_SC0, 8'h90 | m);
      chk("masked", 8'(irq[0]), 8'h00);
      wr(IDX_SC0, 8'h10 | m);
      rd("flag cleared", IDX_SC0, 8'h10 | m);
    end
    // capture edges on channel 1 with the counter held at zero
    wr(IDX_CH1_HI, 8'hAB);
    wr(IDX_CH1_LO, 8'hCD);
    for (int s = 1; s < 4; s++) begin
      drv[1] <= 1'b0;
      repeat (3) @(posedge clk_sys);
      wr(IDX_SC1, 8'h40 | 8'(s << 2));
      drv[1] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("rise", 8'(irq[1]), 8'(s & 1));
      clr(IDX_SC1, 8'h40 | 8'(s << 2));
      drv[1] <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk("fall", 8'(irq[1]), 8'(s >> 1));
      clr(IDX_SC1, 8'h40 | 8'(s << 2));
    end
    rd("capt hi", IDX_CH1_HI, 8'h00);
    drv[1] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("locked", 8'(irq[1]), 8'h00);
    rd("capt lo", IDX_CH1_LO, 8'h00);
    drv[1] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("unlocked", 8'(irq[1]), 8'h01);
    // overflow at a short modulo toggles the compare pin once per period
    wr(IDX_TSC, 8'h30);
    wr(IDX_MOD_HI, 8'h00);
    wr(IDX_MOD_LO, 8'h10);
    wr(IDX_SC0, 8'h16);
    wr(IDX_TSC, 8'h00);
    tg = 0;
    pv = ch_pin_out[0];
    repeat (60) begin
      @(posedge clk_sys);
      if (ch_pin_out[0] !== pv) tg++;
      pv = ch_pin_out[0];
    end
    chk("toggles", 8'(tg), 8'h03);
    wr(IDX_TSC, 8'h30);
    rd("ovf flag", IDX_TSC, 8'hA0);
    // a lone high write holds off matches until the low byte follows
    wr(IDX_SC0, 8'h54);
    wr(IDX_CH0_HI, 8'h00);
    wr(IDX_CH0_LO, 8'h08);
    wr(IDX_CH0_HI, 8'h00);
    wr(IDX_TSC, 8'h00);
    repeat (40) @(posedge clk_sys);
    chk("cmp locked", 8'(irq[0]), 8'h00);
    wr(IDX_CH0_LO, 8'h08);
    wait_irq(0);
    chk("cmp unlocked", 8'(irq[0]), 8'h01);
    // reset in mid-run with a flag pending
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("oe", 8'(ch_pin_oe_n), 8'h03);
    chk("irq", 8'(irq), 8'h00);
    resetn <= 1'b1;
    rd("tsc", IDX_TSC, 8'h20);
    rd("sc1", IDX_SC1, 8'h00);
    final_report();
  end
endmodule
